// [rtl/trsgd_top.sv]
`timescale 1ns/1ps
// Behaviour
// - Read timing from master tick, 25.6 kHz only with high pair and high density request
// - Four-bit skew counter, preset then counts
// - Plain read presets skew counter to 15
// - Read-after-write presets skew counter to 11
// - Read test presets skew counter to 4
// - Data present captured, then counter enabled
// - Carry registered, read clock next tick
// - Read clock lasts one master interval
// - Third tick after terminal: register clear
// - Register clear held while busy
// - Fourth tick data present: skew error lamp
// - Gap counter cleared during block data
// - Twelve data-rate ticks set gap found
// - Gap found qualified, held until block/deselect
// - High density request picks higher density
// - Indicator needs request, selected, not LP/busy
// - Two density pairs by configuration
// - Clock division follows selected density
// - Two anti-phase data-rate test squarewaves
// - Test waves only with armed and test
module trsgd_top
   import trsgd_pkg::*;
#(
   parameter int unsigned DIV_556 = MASTER_DIV_556,
   parameter int unsigned DIV_200 = MASTER_DIV_200
) (
   // Clock, reset, enable
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   input  wire logic        i_ce,
   // Transport pins
   input  wire logic        i_data_present,
   input  wire logic        i_busy,
   input  wire logic        i_unit_selected,
   input  wire logic        i_at_load_point,
   input  wire logic        i_high_density_request,
   input  wire logic        i_write_armed,
   input  wire logic        i_test_mode_select,
   // Read and status outputs
   output logic             o_read_clock,
   output logic             o_read_register_clear,
   output logic             o_skew_lamp,
   output logic             o_gap_found,
   output logic             o_high_density_indicator,
   output logic             o_density_lamp,
   output logic             o_test_phase_a,
   output logic             o_test_phase_b,
   // AHB-Lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata
);

   generate
      if (DIV_556 < 2 || DIV_556 >= 65536 || DIV_200 < 2
          || DIV_200 >= 65536) begin : g_bad_div
         $error("trsgd_top: master divider out of range");
      end
   endgenerate
   // Synchronised pins
   logic [N_PINS-1:0] pins_s;
   logic              dp_s;
   logic              busy_s;
   logic              sel_s;
   logic              lp_s;
   logic              hdr_s;
   logic              wa_s;
   logic              tm_s;

   trsgd_sync3 #(.W(N_PINS)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_ce      (i_ce),
      .i_async   ({i_data_present, i_busy, i_unit_selected,
                   i_at_load_point, i_high_density_request,
                   i_write_armed, i_test_mode_select}),
      .o_level   (pins_s)
   );

   assign {dp_s, busy_s, sel_s, lp_s, hdr_s, wa_s, tm_s} = pins_s;
   // Registers
   logic              pair_high_r;
   logic              skew_err_r;
   logic [7:0]        skew_events_r;
   // Density and tick generation
   logic [DIV_W-1:0]  master_div;
   logic              master_tick;
   logic              half_tick;
   logic              sq_r;
   logic              data_rate_tick;

   always_comb begin
      // Higher of the pair when requested, lower otherwise
      if (pair_high_r) begin
         master_div = hdr_s ? DIV_W'(MASTER_DIV_800)
                            : DIV_W'(DIV_556);
      end else begin
         master_div = hdr_s ? DIV_W'(DIV_556) : DIV_W'(DIV_200);
      end
   end

   trsgd_div #(.W(DIV_W)) u_master (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_ce      (i_ce),
      .i_adv     (1'b1),
      .i_div     (master_div),
      .o_pulse   (master_tick)
   );
   trsgd_div #(.W(DIV_W)) u_rate (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_ce      (i_ce),
      .i_adv     (master_tick),
      .i_div     (RATE_HALF_DIV),
      .o_pulse   (half_tick)
   );

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         sq_r <= 1'b0;
      end else if (i_ce && half_tick) begin
         sq_r <= ~sq_r;
      end
   end
   assign data_rate_tick = half_tick && sq_r;
   // Skew counter and read sequencing
   logic        started_r;
   logic [3:0]  skew_cnt_r;
   logic [3:0]  seq_r;
   logic [3:0]  preset;
   logic        term;
   logic [11:0] lamp_cnt_r;
   always_comb begin
      if (tm_s && !wa_s) begin
         preset = PRESET_TEST;
      end else if (wa_s) begin
         preset = PRESET_RAW;
      end else begin
         preset = PRESET_READ;
      end
   end
   // Counter idles while a clock/clear/check sequence runs
   assign term = started_r && (skew_cnt_r == SKEW_TERM) && (seq_r == 4'h0);

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         started_r  <= 1'b0;
         skew_cnt_r <= PRESET_READ;
      end else if (i_ce && master_tick) begin
         started_r <= dp_s;
         if (!started_r || seq_r[0]) begin
            skew_cnt_r <= preset;
         end else if (seq_r == 4'h0 && skew_cnt_r != SKEW_TERM) begin
            skew_cnt_r <= skew_cnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         seq_r <= 4'h0;
      end else if (i_ce && master_tick) begin
         // Carry, read clock, clear, skew check on successive ticks
         seq_r <= {seq_r[2:0], term};
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_read_clock          <= 1'b0;
         o_read_register_clear <= 1'b0;
      end else if (i_ce) begin
         o_read_clock          <= seq_r[1];
         o_read_register_clear <= seq_r[2] || busy_s;
      end
   end
   logic skew_hit;
   assign skew_hit = master_tick && seq_r[2] && dp_s;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         lamp_cnt_r  <= 12'h000;
         o_skew_lamp <= 1'b0;
      end else if (i_ce) begin
         if (skew_hit) begin
            lamp_cnt_r  <= SKEW_LAMP_TICKS;
            o_skew_lamp <= 1'b1;
         end else if (master_tick && lamp_cnt_r != 12'h000) begin
            lamp_cnt_r  <= lamp_cnt_r - 12'h001;
            o_skew_lamp <= (lamp_cnt_r != 12'h001);
         end
      end
   end
   // Gap detection
   logic       dp_d_r;
   logic [3:0] gap_cnt_r;
   logic       gap_lock_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         dp_d_r     <= 1'b0;
         gap_cnt_r  <= 4'h0;
         gap_lock_r <= 1'b0;
      end else if (i_ce) begin
         dp_d_r <= dp_s;
         if (dp_s) begin
            gap_cnt_r <= 4'h0;
         end else if (data_rate_tick && !gap_lock_r) begin
            gap_cnt_r <= gap_cnt_r + 4'h1;
         end
         if ((dp_s && !dp_d_r) || !sel_s) begin
            gap_lock_r <= 1'b0;
         end else if (!dp_s && data_rate_tick && !gap_lock_r
                      && gap_cnt_r == GAP_COUNT - 4'h1) begin
            gap_lock_r <= 1'b1;
         end
      end
   end
   // Qualified outputs
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_gap_found              <= 1'b0;
         o_high_density_indicator <= 1'b0;
         o_density_lamp           <= 1'b0;
         o_test_phase_a           <= 1'b0;
         o_test_phase_b           <= 1'b0;
      end else if (i_ce) begin
         o_gap_found <= gap_lock_r && sel_s && !lp_s && !busy_s;
         o_high_density_indicator <= hdr_s && sel_s && !lp_s
                                     && !busy_s;
         o_density_lamp <= hdr_s && sel_s && !lp_s && !busy_s;
         o_test_phase_a <= wa_s && tm_s && sq_r;
         o_test_phase_b <= wa_s && tm_s && !sq_r;
      end
   end
   // AHB-Lite slave, zero wait states
   logic       addr_ok;
   logic       wr_pend_r;
   logic [3:0] wr_ofs_r;
   logic [3:0] rd_ofs;
   logic [31:0] rd_mux;

   assign addr_ok = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
   assign rd_ofs  = i_haddr[3:0];
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (rd_ofs)
         REG_CTRL_OFS: rd_mux[CTRL_PAIR_BIT] = pair_high_r;
         REG_STATUS_OFS: begin
            rd_mux[ST_GAP_BIT]     = gap_lock_r;
            rd_mux[ST_HDI_BIT]     = o_high_density_indicator;
            rd_mux[ST_SKEWERR_BIT] = skew_err_r;
            rd_mux[ST_BUSY_BIT]    = busy_s;
            rd_mux[ST_DP_BIT]      = dp_s;
            rd_mux[ST_ACTIVE_BIT]  = started_r;
         end
         REG_SKEWCNT_OFS: rd_mux[7:0] = skew_events_r;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         wr_pend_r   <= 1'b0;
         wr_ofs_r    <= 4'h0;
         o_hrdata    <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else if (i_ce) begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         wr_pend_r   <= addr_ok && i_hwrite;
         wr_ofs_r    <= rd_ofs;
         if (addr_ok && !i_hwrite) begin
            o_hrdata <= rd_mux;
         end
      end
   end
   logic wr_ctrl;
   logic wr_stat;
   assign wr_ctrl = wr_pend_r && wr_ofs_r == REG_CTRL_OFS;
   assign wr_stat = wr_pend_r && wr_ofs_r == REG_STATUS_OFS;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         pair_high_r <= CTRL_PAIR_RST;
      end else if (i_ce && wr_ctrl) begin
         pair_high_r <= i_hwdata[CTRL_PAIR_BIT];
      end
   end
   // Sticky skew error: a new hit beats a same-cycle clear
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         skew_err_r    <= 1'b0;
         skew_events_r <= 8'h00;
      end else if (i_ce) begin
         if (skew_hit) begin
            skew_err_r <= 1'b1;
         end else if (wr_stat && i_hwdata[ST_SKEWERR_BIT]) begin
            skew_err_r <= 1'b0;
         end
         if (skew_hit) begin
            if (skew_events_r != 8'hff) begin
               skew_events_r <= skew_events_r + 8'h01;
            end
         end else if (wr_stat && i_hwdata[ST_SKEWERR_BIT]) begin
            skew_events_r <= 8'h00;
         end
      end
   end
   // Checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);

   a_preset_load: assert property (i_ce && master_tick && seq_r[0]
      |=> skew_cnt_r == $past(preset))
      else $error("skew counter not reloaded with preset");
   a_preset_test: assert property (i_ce && master_tick && seq_r[0]
      && tm_s && !wa_s |=> skew_cnt_r == 4'h4)
      else $error("read test preset is not four");
   a_clock_order: assert property ($rose(o_read_clock)
      |-> $past(seq_r[1]) && !$past(seq_r[0]))
      else $error("read clock not one tick after carry");
   a_clear_busy: assert property (i_ce && busy_s
      |=> o_read_register_clear)
      else $error("register clear missing while busy");
   a_skew_lamp_on: assert property (i_ce && skew_hit
      |=> o_skew_lamp && skew_err_r)
      else $error("skew hit did not light lamp");
   a_gap_twelve: assert property ($rose(gap_lock_r)
      |-> gap_cnt_r == GAP_COUNT)
      else $error("gap found not at count twelve");
   a_gap_cleared: assert property (i_ce && dp_s
      |=> gap_cnt_r == 4'h0)
      else $error("gap counter running during block");
   a_gap_qual: assert property (o_gap_found
      |-> $past(gap_lock_r && sel_s && !lp_s && !busy_s))
      else $error("gap found not qualified");
   a_hdi_qual: assert property ($past(i_ce) |-> o_high_density_indicator
      == $past(hdr_s && sel_s && !lp_s && !busy_s))
      else $error("density indicator wrong");
   a_test_gate: assert property (o_test_phase_a || o_test_phase_b
      |-> $past(wa_s && tm_s))
      else $error("test wave outside write test");
   a_test_anti: assert property ($past(i_ce && wa_s && tm_s)
      |-> o_test_phase_a != o_test_phase_b)
      else $error("test waves not in anti-phase");

   c_read_clock: cover property ($rose(o_read_clock));
   c_gap_found:  cover property ($rose(o_gap_found));
   c_skew_lamp:  cover property ($rose(o_skew_lamp));
   c_test_waves: cover property ($rose(o_test_phase_b));

endmodule

// [rtl/trsgd_pkg.sv]
package trsgd_pkg;

   // System clock and master tick timing
   localparam int unsigned SYS_CLK_HZ     = 100_000_000;
   localparam int unsigned MASTER_HZ      = 25_600;
   // Rounded down: the tick runs a hair fast rather than slow
   localparam int unsigned MASTER_DIV_800 = SYS_CLK_HZ / MASTER_HZ;
   localparam int unsigned DIV_W          = 16;
   // Default stretch of the master period for the slower densities
   localparam int unsigned MASTER_DIV_556 = (MASTER_DIV_800 * 800) / 556;
   localparam int unsigned MASTER_DIV_200 = (MASTER_DIV_800 * 800) / 200;

   // Data-rate tick is master tick divided by 32, made of two halves
   localparam logic [DIV_W-1:0] RATE_HALF_DIV = 16'h0010;

   // Skew counter: four bits, counts up to 15 and holds there, presets per mode
   localparam logic [3:0] SKEW_TERM        = 4'hf;
   localparam logic [3:0] PRESET_READ      = 4'hf;
   localparam logic [3:0] PRESET_RAW       = 4'hb;
   localparam logic [3:0] PRESET_TEST      = 4'h4;

   // Gap detection after 12 data-rate ticks
   localparam logic [3:0] GAP_COUNT        = 4'hc;

   // Skew lamp on-time in master ticks (about 100 ms)
   localparam logic [11:0] SKEW_LAMP_TICKS = 12'ha00;

   // Register byte offsets
   localparam logic [3:0] REG_CTRL_OFS     = 4'h0;
   localparam logic [3:0] REG_STATUS_OFS   = 4'h4;
   localparam logic [3:0] REG_SKEWCNT_OFS  = 4'h8;

   // Control fields
   localparam int unsigned CTRL_PAIR_BIT   = 0;
   localparam logic        CTRL_PAIR_RST   = 1'b1;

   // Status fields
   localparam int unsigned ST_GAP_BIT      = 0;
   localparam int unsigned ST_HDI_BIT      = 1;
   localparam int unsigned ST_SKEWERR_BIT  = 2;
   localparam int unsigned ST_BUSY_BIT     = 3;
   localparam int unsigned ST_DP_BIT       = 4;
   localparam int unsigned ST_ACTIVE_BIT   = 5;

   // AHB transfer type
   localparam logic [1:0] HTRANS_NONSEQ    = 2'h2;

   // Number of pin inputs passing the synchroniser
   localparam int unsigned N_PINS          = 7;

endpackage

// [rtl/trsgd_sync3.sv]
`timescale 1ns/1ps
module trsgd_sync3 #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_srst,
   input  wire logic         i_ce,
   // Pins in, settled levels out
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_level
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         s1_r    <= '0;
         s2_r    <= '0;
         s3_r    <= '0;
         o_level <= '0;
      end else if (i_ce) begin
         s1_r <= i_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // A bit changes only once two late stages agree
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               o_level[i] <= s3_r[i];
            end
         end
      end
   end

endmodule

// [rtl/trsgd_div.sv]
`timescale 1ns/1ps
module trsgd_div #(
   parameter int unsigned W = 16
) (
   // Clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_srst,
   input  wire logic         i_ce,
   // Advance strobe and period
   input  wire logic         i_adv,
   input  wire logic [W-1:0] i_div,
   output logic              o_pulse
);

   logic [W-1:0] cnt_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cnt_r   <= '0;
         o_pulse <= 1'b0;
      end else if (i_ce) begin
         o_pulse <= 1'b0;
         if (i_adv) begin
            // Period change takes effect at the next wrap at latest
            if (cnt_r >= i_div - W'(1)) begin
               cnt_r   <= '0;
               o_pulse <= 1'b1;
            end else begin
               cnt_r <= cnt_r + W'(1);
            end
         end
      end
   end

endmodule

// [dv/trsgd_fmt_model.sv]
`timescale 1ns/1ps
module trsgd_fmt_model (
   // Clock
   input  wire logic i_sys_clk,
   // Character arrival and register clear
   input  wire logic i_char,
   input  wire logic i_clear,
   // Combined data-present of the read channels
   output logic      o_data_present
);
   initial o_data_present = 1'b0;
   // A character landing during a clear still sets its register
   always @(posedge i_sys_clk) begin
      if (i_char) begin
         o_data_present <= 1'b1;
      end else if (i_clear) begin
         o_data_present <= 1'b0;
      end
   end
endmodule

// [dv/trsgd_top_bench.sv]
`timescale 1ns/1ps
module trsgd_top_bench;
   import trsgd_pkg::*;
   localparam int D556 = 20;
   localparam int D200 = 40;
   logic        clk = 1'b0, srst = 1'b1, chr = 1'b0;
   logic        busy = 1'b0, sel = 1'b1, lp = 1'b0, hdr = 1'b1;
   logic        wa = 1'b0, tm = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        ce = 1'b1;
   logic        dp, rclk, rclr, lamp, gap, high_density_indicator, dlamp, tpa, tpb;
   logic        hready, hresp;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [4:0]  obs;
   int          fail_count = 0;
   int          total_checks = 0;

   assign obs = {tpa, gap, lamp, rclr, rclk};
   always #5 clk = ~clk;

   trsgd_fmt_model fmt (.i_sys_clk(clk), .i_char(chr), .i_clear(rclr),
      .o_data_present(dp));

   trsgd_top #(.DIV_556(D556), .DIV_200(D200)) dut (
      .i_sys_clk(clk), .i_srst(srst), .i_ce(ce),
      .i_data_present(dp), .i_busy(busy), .i_unit_selected(sel),
      .i_at_load_point(lp), .i_high_density_request(hdr),
      .i_write_armed(wa), .i_test_mode_select(tm),
      .o_read_clock(rclk), .o_read_register_clear(rclr),
      .o_skew_lamp(lamp), .o_gap_found(gap),
      .o_high_density_indicator(high_density_indicator), .o_density_lamp(dlamp),
      .o_test_phase_a(tpa), .o_test_phase_b(tpb),
      .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
      .o_hrdata(hrdata));

   task automatic finish_test;
      $display("Checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Counts cycles until the watched output reaches the level
   task automatic wait_obs(input int idx, input logic v, input int lim,
                           output int n);
      n = 0;
      while (obs[idx] !== v) begin
         @(posedge clk);
         #1;
         n++;
         if (n > lim) begin
            fail_count++;
            $display("Error wait %0d expected %b seen timeout", idx, v);
            finish_test;
         end
      end
   endtask

   task automatic settle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // Single AHB-Lite word; the bench owns no wait-state count
   task automatic ahb(input logic wr, input logic [31:0] a, d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      q = hrdata;
      chk("hresp", 0, 32'(hresp));
      if (n >= 50) begin
         fail_count++;
         $display("Error bus expected ready seen timeout");
         finish_test;
      end
   endtask

   task automatic pulse_char(input int k);
      @(posedge clk);
      chr <= 1'b1;
      repeat (k) @(posedge clk);
      chr <= 1'b0;
   endtask

   task automatic t_reset;
      logic [31:0] q;
      settle(1);
      chk("read clock", 0, rclk);
      chk("gap found", 0, gap);
      chk("skew lamp", 0, lamp);
      chk("hreadyout", 1, hready);
      ahb(1'b0, 32'(REG_CTRL_OFS), 32'h0, q);
      chk("ctrl reset", 1, q);
      ahb(1'b1, 32'(REG_CTRL_OFS), 32'h0, q);
      ahb(1'b0, 32'(REG_CTRL_OFS), 32'h0, q);
      chk("ctrl pair", 0, q);
      ahb(1'b0, 32'hc, 32'h0, q);
      chk("unmapped", 0, q);
      $display("test reset done");
   endtask

   task automatic t_char(input logic w, t, h, input int p);
      int d, n;
      d = h ? D556 : D200;
      @(posedge clk);
      wa <= w;
      tm <= t;
      hdr <= h;
      settle(8);
      pulse_char(1);
      wait_obs(0, 1'b1, 40 * d, n);
      chk("char to read clock", 1,
          32'(n >= (17 - p) * d && n <= (18 - p) * d + 8));
      wait_obs(0, 1'b0, 2 * d, n);
      chk("read clock width", d, n);
      wait_obs(1, 1'b1, 4, n);
      wait_obs(1, 1'b0, 2 * d, n);
      chk("clear width", d, n);
      chk("data present", 0, dp);
      settle(2 * d);
      chk("skew lamp", 0, lamp);
      $display("test char preset %0d done", p);
   endtask

   task automatic t_skew;
      int n;
      logic [31:0] q;
      @(posedge clk);
      wa <= 1'b0;
      tm <= 1'b0;
      hdr <= 1'b1;
      settle(8);
      pulse_char(1);
      wait_obs(1, 1'b1, 40 * D556, n);
      repeat (D556 - 10) @(posedge clk);
      pulse_char(14);
      wait_obs(2, 1'b1, 2 * D556, n);
      settle(10 * D556);
      ahb(1'b0, 32'(REG_STATUS_OFS), 32'h0, q);
      chk("sticky skew", 1, 32'(q[ST_SKEWERR_BIT]));
      ahb(1'b0, 32'(REG_SKEWCNT_OFS), 32'h0, q);
      chk("skew count", 1, q);
      ahb(1'b1, 32'(REG_STATUS_OFS), 32'h4, q);
      ahb(1'b0, 32'(REG_STATUS_OFS), 32'h0, q);
      chk("skew w1c", 0, 32'(q[ST_SKEWERR_BIT]));
      ahb(1'b0, 32'(REG_SKEWCNT_OFS), 32'h0, q);
      chk("skew count clear", 0, q);
      @(posedge clk);
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      settle(1);
      chk("lamp after reset", 0, lamp);
      ahb(1'b0, 32'(REG_CTRL_OFS), 32'h0, q);
      chk("ctrl after reset", 1, q);
      ahb(1'b1, 32'(REG_CTRL_OFS), 32'h0, q);
      $display("test skew done");
   endtask

   task automatic t_busy;
      @(posedge clk);
      busy <= 1'b1;
      settle(8);
      chk("clear on busy", 1, rclr);
      settle(100);
      chk("clear held", 1, rclr);
      busy <= 1'b0;
      settle(8);
      chk("clear released", 0, rclr);
      $display("test busy done");
   endtask

   task automatic t_density;
      logic e;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         {hdr, sel, lp, busy} <= 4'(i);
         settle(8);
         e = hdr & sel & ~lp & ~busy;
         chk("hd indicator", 32'(e), 32'(high_density_indicator));
         chk("density lamp", 32'(e), 32'(dlamp));
      end
      {hdr, sel, lp, busy} <= 4'hc;
      $display("test density done");
   endtask

   task automatic t_gap;
      int n;
      pulse_char(1);
      wait_obs(1, 1'b1, 40 * D556, n);
      chk("gap cleared", 0, gap);
      wait_obs(1, 1'b0, 2 * D556, n);
      wait_obs(3, 1'b1, 14 * 32 * D556, n);
      chk("gap delay", 1, 32'(n >= 11 * 32 * D556
          && n <= 12 * 32 * D556 + 40));
      @(posedge clk);
      lp <= 1'b1;
      settle(8);
      chk("gap at load point", 0, gap);
      lp <= 1'b0;
      settle(8);
      chk("gap held", 1, gap);
      busy <= 1'b1;
      settle(8);
      chk("gap while busy", 0, gap);
      busy <= 1'b0;
      settle(8);
      chk("gap after busy", 1, gap);
      pulse_char(1);
      wait_obs(1, 1'b1, 40 * D556, n);
      chk("gap new block", 0, gap);
      wait_obs(1, 1'b0, 2 * D556, n);
      wait_obs(3, 1'b1, 14 * 32 * D556, n);
      sel <= 1'b0;
      settle(8);
      sel <= 1'b1;
      settle(8);
      chk("gap after deselect", 0, gap);
      $display("test gap done");
   endtask

   task automatic t_waves;
      int n;
      @(posedge clk);
      wa <= 1'b1;
      tm <= 1'b1;
      settle(8);
      wait_obs(4, 1'b1, 40 * D556, n);
      chk("phase b low", 0, tpb);
      wait_obs(4, 1'b0, 40 * D556, n);
      chk("half period", 16 * D556, n);
      chk("phase b high", 1, tpb);
      ce <= 1'b0;
      settle(400);
      chk("frozen waves", 32'h1, {tpa, tpb});
      ce <= 1'b1;
      wa <= 1'b0;
      settle(8);
      chk("waves off a", 0, {tpa, tpb});
      wa <= 1'b1;
      tm <= 1'b0;
      settle(8);
      chk("waves off b", 0, {tpa, tpb});
      $display("test waves done");
   endtask

   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      t_reset;
      t_char(1'b0, 1'b0, 1'b1, 15);
      t_char(1'b1, 1'b0, 1'b1, 11);
      t_char(1'b0, 1'b1, 1'b1, 4);
      t_char(1'b0, 1'b0, 1'b0, 15);
      t_skew;
      t_busy;
      t_density;
      t_gap;
      t_waves;
      finish_test;
   end
endmodule
